// ===== design/phy_mgmt_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the management register block, checker, controller model and bench
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

// ----------------------------------------------------------------------
// Standard register offsets
// ----------------------------------------------------------------------
`define REG_INT_ENABLE      5'h12
`define REG_INT_STATUS      5'h13
`define REG_SPEED_CFG       5'h14
`define REG_RX_ERR_COUNT    5'h15
`define REG_EXT_POINTER     5'h1E
`define REG_EXT_WINDOW      5'h1F

// ----------------------------------------------------------------------
// Extended register offsets
// ----------------------------------------------------------------------
`define EXT_TEN_MEG_POWER   16'h200A
`define EXT_COMBO           16'h4000
`define EXT_PAD             16'h4001
`define EXT_COMBO2          16'h4003

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INT_ENABLE      16'h0000
`define RST_SPEED_CFG       16'h082C
`define RST_EXT_POINTER     16'h0000
`define RST_TEN_MEG_POWER   16'hCA02
`define RST_COMBO           16'h0000
`define RST_PAD             16'h80EF
`define RST_COMBO2          16'h0260

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define INT_IMPL_MASK       16'hFC63
`define INT_DOWNGRADE_BIT   5
`define INT_WAKE_BIT        6
`define SPD_WRITE_MASK      16'h0FFE
`define SPD_LATCH_BIT       11
`define SPD_DG_EN_BIT       5
`define SPD_ATT_MSB         4
`define SPD_ATT_LSB         2
`define SPD_BYPASS_BIT      1
`define SPD_ATT_EXTRA       4'h2
`define PWR_IDLE_OFF_BIT    10
`define COMBO_JUMBO_BIT     5
`define COMBO_CRSDV_BIT     4
`define COMBO_RMII_BIT      1
`define COMBO_CLKSEL_BIT    0
`define PAD_IRQ_SEL_BIT     15

// ----------------------------------------------------------------------
// Frame limits and timing
// ----------------------------------------------------------------------
`define FRAME_MAX_JUMBO     16'h4800
`define FRAME_MAX_NORMAL    16'h1200
`define RX_ERR_SAT          16'hFFFF
`define CLK_FREQ_HZ         40000000
`define STABLE_TIME_MS      2500

`endif

// ===== design/phy_mgmt_pkg.sv
// Types shared by the management register block
// Assumes the defs header sits beside it
package phy_mgmt_pkg;

  // Downgrade link stability states
  typedef enum logic [1:0] {
    DG_WAIT,
    DG_CHECK,
    DG_UP
  } dg_state_t;

  // Extended register select code
  typedef enum logic [2:0] {
    EXT_SEL_NONE,
    EXT_SEL_POWER,
    EXT_SEL_COMBO,
    EXT_SEL_PAD,
    EXT_SEL_COMBO2
  } ext_sel_t;

  // All state of the register block
  typedef struct packed {
    logic [15:0] int_en;
    logic [15:0] int_stat;
    logic [15:0] spd_cfg;
    logic        dg_en_act;
    logic [3:0]  dg_lim_act;
    logic [15:0] rx_err_cnt;
    logic [15:0] ext_ptr;
    logic [15:0] ten_pwr;
    logic [15:0] combo;
    logic [15:0] pad;
    logic [15:0] combo2;
    logic        strap_done;
    logic        strap_irq_pin;
    logic [4:0]  rd_addr;
    logic [15:0] rdata;
    dg_state_t   dg_state;
    logic [31:0] stab_cnt;
    logic [3:0]  fail_cnt;
    logic        downgraded;
    logic        crs_dv;
    logic        dac_on;
  } mgmt_state_t;

endpackage

// ===== design/phy_interrupt_and_config_regs.sv
// Management register block of a 10/100 transceiver: interrupts,
// speed downgrade, receive error count and extended register window.
// Assumes a management frame decoder that presents one-cycle read and
// write strobes with a 5-bit register address, all on sys_clk.
`include "phy_mgmt_defs.svh"

// Operation
// [RULE_01] Enable bit 15 gates the autonegotiation error interrupt.
// [RULE_02] Enable bit 14 gates speed change interrupt; resets to zero.
// [RULE_03] Enable bit 13 gates the duplex change interrupt.
// [RULE_04] Enable bit 12 gates the page received interrupt.
// [RULE_05] Enable bit 11 gates the link failure interrupt.
// [RULE_06] Enable bit 10 gates the link established interrupt.
// [RULE_07] Enable bit 6 gates the wake interrupt.
// [RULE_08] Enable bit 1 gates the polarity change interrupt.
// [RULE_09] Enable bit 0 gates the jabber interrupt.
// [RULE_10] Status bits stick on events and clear when the status register is read.
// [RULE_11] Status bit 5 reports a speed downgrade, enabled by bit 5.
// [RULE_12] With strap high, pad bit 15 picks general or wake interrupt on pin.
// [RULE_13] Speed config bit 11 latches read data during a management read.
// [RULE_14] Speed config bit 5 enables downgrade, applied at software reset.
// [RULE_15] Downgrade after field plus two failed attempts, applied at software reset.
// [RULE_16] Unless bypassed, a link lasting under 2.5 s counts as failure.
// [RULE_17] Receive error counter counts errors and saturates at all ones.
// [RULE_18] Extended registers reached by pointer at 0x1E and data at 0x1F.
// [RULE_19] With idle-off set, 10M transmit DAC turns off when nothing to send.
// [RULE_20] Combo bit 5 raises the receive frame limit to 18KB from 4.5KB.
// [RULE_21] Combo bit 4 picks receive valid or carrier-valid for the RMII pin.
// [RULE_22] Combo bits 1:0 select MII, reverse MII, RMII two or RMII one.
// [RULE_23] General interrupt is high while any enabled status bit is set.
module phy_interrupt_and_config_regs
  import phy_mgmt_pkg::*;
#(
  parameter int STABLE_CYCLES = `STABLE_TIME_MS * (`CLK_FREQ_HZ / 1000)
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  input  wire logic        soft_reset,
  input  wire logic [15:0] event_pulse,
  input  wire logic        wake_irq_level,
  input  wire logic        strap_irq_pin,
  input  wire logic        strap_clk_input,
  input  wire logic        link_up,
  input  wire logic        autoneg_attempt_fail,
  input  wire logic        rx_error,
  input  wire logic        speed_10m,
  input  wire logic        tx_data_pending,
  input  wire logic        link_pulse_pending,
  input  wire logic        rx_dv_in,
  input  wire logic        crs_dv_in,
  output logic             general_irq,
  output logic             shared_irq_pin,
  output logic             downgrade_active,
  output logic             tx_dac_on,
  output logic [15:0]      max_rx_frame_bytes,
  output logic             rmii_crs_dv,
  output logic             reduced_interface_variant_one,
  output logic             reduced_interface_variant_two,
  output logic             reverse_media_interface,
  output logic             mac_clock_input,
  output logic             remote_loopback,
  output logic             wake_enable
);

  // ----------------------------------------------------------------------
  // Extended address decode
  // ----------------------------------------------------------------------
  function automatic ext_sel_t ext_decode(input logic [15:0] ptr);
    case (ptr)
      `EXT_TEN_MEG_POWER: ext_decode = EXT_SEL_POWER;
      `EXT_COMBO:         ext_decode = EXT_SEL_COMBO;
      `EXT_PAD:           ext_decode = EXT_SEL_PAD;
      `EXT_COMBO2:        ext_decode = EXT_SEL_COMBO2;
      default:            ext_decode = EXT_SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mgmt_state_t st_r;
  mgmt_state_t st_nxt;
  ext_sel_t    ext_sel;
  logic [15:0] ext_rd_val;
  logic [15:0] live_val;
  logic [15:0] stat_set;
  logic [15:0] stat_clr;
  logic        dg_fail;
  logic        dg_pulse;
  logic [3:0]  fail_inc;
  logic        stable_done;

  // Extended window read mux
  always_comb begin
    ext_sel = ext_decode(st_r.ext_ptr); // RULE_18
    case (ext_sel)
      EXT_SEL_POWER:  ext_rd_val = st_r.ten_pwr;
      EXT_SEL_COMBO:  ext_rd_val = st_r.combo;
      EXT_SEL_PAD:    ext_rd_val = st_r.pad;
      EXT_SEL_COMBO2: ext_rd_val = st_r.combo2;
      default:        ext_rd_val = 16'h0000;
    endcase
  end

  // Standard register read mux on the strobed address during a read, else the held read address
  always_comb begin
    case (mgmt_rd ? mgmt_addr : st_r.rd_addr)
      `REG_INT_ENABLE:   live_val = st_r.int_en;
      `REG_INT_STATUS:   live_val = st_r.int_stat;
      `REG_SPEED_CFG:    live_val = st_r.spd_cfg;
      `REG_RX_ERR_COUNT: live_val = st_r.rx_err_cnt;
      `REG_EXT_POINTER:  live_val = st_r.ext_ptr;
      `REG_EXT_WINDOW:   live_val = ext_rd_val; // RULE_18
      default:           live_val = 16'h0000;
    endcase
  end

  // Stability timer expiry
  assign stable_done = (st_r.stab_cnt >= 32'(STABLE_CYCLES - 1));
  assign fail_inc    = st_r.fail_cnt + 4'h1;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    dg_fail  = 1'b0;
    dg_pulse = 1'b0;

    // Strap capture once after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done    = 1'b1;
      st_nxt.strap_irq_pin = strap_irq_pin;
      st_nxt.combo[`COMBO_CLKSEL_BIT] = strap_clk_input; // RULE_22
    end

    // Register writes
    if (mgmt_wr) begin
      case (mgmt_addr)
        `REG_INT_ENABLE:  st_nxt.int_en  = mgmt_wdata; // RULE_01 RULE_02 RULE_03
        `REG_SPEED_CFG:   st_nxt.spd_cfg = (st_r.spd_cfg & ~`SPD_WRITE_MASK)
                                         | (mgmt_wdata & `SPD_WRITE_MASK);
        `REG_EXT_POINTER: st_nxt.ext_ptr = mgmt_wdata; // RULE_18
        `REG_EXT_WINDOW: begin
          case (ext_sel) // RULE_18
            EXT_SEL_POWER:  st_nxt.ten_pwr = mgmt_wdata;
            EXT_SEL_COMBO:  st_nxt.combo   = mgmt_wdata;
            EXT_SEL_PAD:    st_nxt.pad     = mgmt_wdata;
            EXT_SEL_COMBO2: st_nxt.combo2  = mgmt_wdata;
            default:        st_nxt.ten_pwr = st_r.ten_pwr;
          endcase
        end
        default: st_nxt.int_en = st_r.int_en;
      endcase
    end

    // Software reset applies pending downgrade settings
    if (soft_reset) begin
      st_nxt.dg_en_act  = st_r.spd_cfg[`SPD_DG_EN_BIT]; // RULE_14
      st_nxt.dg_lim_act = {1'b0, st_r.spd_cfg[`SPD_ATT_MSB:`SPD_ATT_LSB]}
                        + `SPD_ATT_EXTRA; // RULE_15
      st_nxt.dg_state   = DG_WAIT;
      st_nxt.fail_cnt   = 4'h0;
      st_nxt.stab_cnt   = 32'h0000_0000;
      st_nxt.downgraded = 1'b0;
    end else begin
      // Link stability and retry tracking
      case (st_r.dg_state)
        DG_WAIT: begin
          st_nxt.stab_cnt = 32'h0000_0000;
          if (link_up) begin
            if (st_r.spd_cfg[`SPD_BYPASS_BIT]) begin // RULE_16
              st_nxt.dg_state = DG_UP;
              st_nxt.fail_cnt = 4'h0;
            end else begin
              st_nxt.dg_state = DG_CHECK;
            end
          end else if (autoneg_attempt_fail) begin
            dg_fail = 1'b1;
          end
        end
        DG_CHECK: begin
          if (!link_up) begin
            dg_fail         = 1'b1; // RULE_16
            st_nxt.dg_state = DG_WAIT;
          end else if (stable_done) begin
            st_nxt.dg_state = DG_UP;
            st_nxt.fail_cnt = 4'h0;
          end else begin
            st_nxt.stab_cnt = st_r.stab_cnt + 32'h0000_0001;
          end
        end
        DG_UP: begin
          if (!link_up) begin
            st_nxt.dg_state = DG_WAIT;
          end
        end
        default: st_nxt.dg_state = DG_WAIT;
      endcase

      // Retry counter and downgrade decision
      if (dg_fail) begin
        if (st_r.dg_en_act && (fail_inc >= st_r.dg_lim_act)) begin // RULE_15
          dg_pulse          = 1'b1; // RULE_14
          st_nxt.downgraded = 1'b1;
          st_nxt.fail_cnt   = 4'h0;
        end else if (fail_inc != 4'h0) begin
          st_nxt.fail_cnt = fail_inc;
        end
      end
    end

    // Sticky status: set wins over clear on read
    stat_set = event_pulse & `INT_IMPL_MASK; // RULE_10
    stat_set[`INT_DOWNGRADE_BIT] = dg_pulse; // RULE_11
    stat_clr = (mgmt_rd && (mgmt_addr == `REG_INT_STATUS)) ? 16'hFFFF : 16'h0000;
    st_nxt.int_stat = (st_r.int_stat & ~stat_clr) | stat_set; // RULE_10

    // Saturating receive error count
    if (rx_error && (st_r.rx_err_cnt != `RX_ERR_SAT)) begin
      st_nxt.rx_err_cnt = st_r.rx_err_cnt + 16'h0001; // RULE_17
    end

    // Read data: latched at the read or following the held address
    if (mgmt_rd) begin
      st_nxt.rd_addr = mgmt_addr;
      st_nxt.rdata   = live_val; // RULE_13
    end else if (!st_r.spd_cfg[`SPD_LATCH_BIT]) begin
      st_nxt.rdata = live_val; // RULE_13
    end

    // RMII carrier/valid pin source
    st_nxt.crs_dv = st_r.combo[`COMBO_CRSDV_BIT] ? rx_dv_in : crs_dv_in; // RULE_21

    // 10M transmit DAC idle shutoff
    st_nxt.dac_on = !(speed_10m && st_r.ten_pwr[`PWR_IDLE_OFF_BIT]
                      && !tx_data_pending && !link_pulse_pending); // RULE_19
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.int_en        <= `RST_INT_ENABLE; // RULE_02
      st_r.int_stat      <= 16'h0000;
      st_r.spd_cfg       <= `RST_SPEED_CFG;
      st_r.dg_en_act     <= 1'b1;
      st_r.dg_lim_act    <= 4'h5;
      st_r.rx_err_cnt    <= 16'h0000;
      st_r.ext_ptr       <= `RST_EXT_POINTER;
      st_r.ten_pwr       <= `RST_TEN_MEG_POWER;
      st_r.combo         <= `RST_COMBO;
      st_r.pad           <= `RST_PAD;
      st_r.combo2        <= `RST_COMBO2;
      st_r.strap_done    <= 1'b0;
      st_r.strap_irq_pin <= 1'b0;
      st_r.rd_addr       <= 5'h00;
      st_r.rdata         <= 16'h0000;
      st_r.dg_state      <= DG_WAIT;
      st_r.stab_cnt      <= 32'h0000_0000;
      st_r.fail_cnt      <= 4'h0;
      st_r.downgraded    <= 1'b0;
      st_r.crs_dv        <= 1'b0;
      st_r.dac_on        <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Interrupt combining and shared pin selection
  assign general_irq    = |(st_r.int_stat & st_r.int_en); // RULE_01 RULE_04 RULE_05 RULE_23
  assign shared_irq_pin = (st_r.strap_irq_pin && !st_r.pad[`PAD_IRQ_SEL_BIT])
                        ? (wake_irq_level && st_r.int_en[`INT_WAKE_BIT]) // RULE_07 RULE_12
                        : general_irq; // RULE_06 RULE_08 RULE_09

  // Mode and data outputs from registers
  assign mgmt_rdata         = st_r.rdata;
  assign downgrade_active   = st_r.downgraded;
  assign tx_dac_on          = st_r.dac_on;
  assign rmii_crs_dv        = st_r.crs_dv;
  assign max_rx_frame_bytes = st_r.combo[`COMBO_JUMBO_BIT]
                            ? `FRAME_MAX_JUMBO : `FRAME_MAX_NORMAL; // RULE_20
  assign reduced_interface_variant_one = st_r.combo[`COMBO_RMII_BIT]
                                       && st_r.combo[`COMBO_CLKSEL_BIT]; // RULE_22
  assign reduced_interface_variant_two = st_r.combo[`COMBO_RMII_BIT]
                                       && !st_r.combo[`COMBO_CLKSEL_BIT];
  assign reverse_media_interface = !st_r.combo[`COMBO_RMII_BIT]
                                 && st_r.combo[`COMBO_CLKSEL_BIT];
  assign mac_clock_input  = st_r.combo[`COMBO_CLKSEL_BIT];
  assign remote_loopback  = st_r.combo[11];
  assign wake_enable      = st_r.combo[2];

endmodule // phy_interrupt_and_config_regs

// ===== tb/phy_regs_props.sv
// Checker for the management register block, bound to its ports
// Assumes straps held steady and the defs header on the include path
`include "phy_mgmt_defs.svh"
// ----------------------------------------------------------------------
// Port relations
// ----------------------------------------------------------------------
module phy_regs_props #(
  parameter int STABLE_CYCLES = 20
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        mgmt_rd,
  input wire logic        mgmt_wr,
  input wire logic [4:0]  mgmt_addr,
  input wire logic        soft_reset,
  input wire logic [15:0] event_pulse,
  input wire logic        strap_irq_pin,
  input wire logic        link_up,
  input wire logic        autoneg_attempt_fail,
  input wire logic        speed_10m,
  input wire logic        tx_data_pending,
  input wire logic        link_pulse_pending,
  input wire logic        rx_dv_in,
  input wire logic        crs_dv_in,
  input wire logic        general_irq,
  input wire logic        shared_irq_pin,
  input wire logic        downgrade_active,
  input wire logic        tx_dac_on,
  input wire logic        rmii_crs_dv,
  input wire logic        reduced_interface_variant_one,
  input wire logic        reduced_interface_variant_two,
  input wire logic        reverse_media_interface,
  input wire logic        mac_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Interrupt line moves only for an event, a write or a read-clear
  property p_irq_rise;
    $rose(general_irq) |-> $past(|event_pulse) || $past(mgmt_wr) || $rose(downgrade_active);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(general_irq) |-> $past(mgmt_rd && mgmt_addr == `REG_INT_STATUS) || $past(mgmt_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
  // Pin source and DAC follow their inputs one cycle later
  property p_crs;
    !$past(rst) |-> rmii_crs_dv == $past(rx_dv_in) || rmii_crs_dv == $past(crs_dv_in);
  endproperty
  a_crs: assert property (p_crs) else $error("carrier valid pin has no source");
  property p_dac;
    !$past(rst) && !($past(speed_10m) && !$past(tx_data_pending) && !$past(link_pulse_pending))
      |-> tx_dac_on;
  endproperty
  a_dac: assert property (p_dac) else $error("dac off while needed");
  property p_decode;
    $onehot0({reduced_interface_variant_one, reduced_interface_variant_two,
              reverse_media_interface})
      && mac_clock_input == (reduced_interface_variant_one || reverse_media_interface);
  endproperty
  a_decode: assert property (p_decode) else $error("interface mode decode bad");
  property p_shared;
    shared_irq_pin != general_irq |-> strap_irq_pin;
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin off general irq");
  // Downgrade needs a recent failure and drops at software reset
  property p_dg_rise;
    $rose(downgrade_active) |-> $past(autoneg_attempt_fail) || $past(autoneg_attempt_fail, 2)
      || $past(autoneg_attempt_fail, 3) || $past(link_up, 2) || $past(link_up, 3);
  endproperty
  a_dg_rise: assert property (p_dg_rise) else $error("downgrade without failure");
  property p_dg_soft;
    soft_reset |=> !downgrade_active;
  endproperty
  a_dg_soft: assert property (p_dg_soft) else $error("downgrade kept over reset");
endmodule // phy_regs_props

bind phy_interrupt_and_config_regs phy_regs_props #(.STABLE_CYCLES(STABLE_CYCLES)) u_props (
  .sys_clk, .rst, .mgmt_rd, .mgmt_wr, .mgmt_addr, .soft_reset, .event_pulse, .strap_irq_pin,
  .link_up, .autoneg_attempt_fail, .speed_10m, .tx_data_pending, .link_pulse_pending,
  .rx_dv_in, .crs_dv_in, .general_irq, .shared_irq_pin, .downgrade_active, .tx_dac_on,
  .rmii_crs_dv, .reduced_interface_variant_one, .reduced_interface_variant_two,
  .reverse_media_interface, .mac_clock_input);

// ===== tb/mgmt_ctrl_model.sv
// Station management controller model for the register port
// Assumes strobes change at the falling edge of the block clock
`include "phy_mgmt_defs.svh"
// ----------------------------------------------------------------------
// Register transfers
// ----------------------------------------------------------------------
module mgmt_ctrl_model (
  input  wire logic        sys_clk,
  output logic             mgmt_rd,
  output logic             mgmt_wr,
  output logic [4:0]       mgmt_addr,
  output logic [15:0]      mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {mgmt_rd, mgmt_wr, mgmt_addr, mgmt_wdata} = '0;
  end
  // One strobe; released lines show the inverse so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    @(negedge sys_clk);
    {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, w};
    @(negedge sys_clk);
    {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b0, ~a, ~w};
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(negedge sys_clk);
    {mgmt_rd, mgmt_addr} = {1'b1, a};
    @(negedge sys_clk);
    {mgmt_rd, mgmt_addr} = {1'b0, ~a};
    q = mgmt_rdata;
  endtask
  // Extended access: pointer first, then the window
  task automatic ext_wr(input logic [15:0] x, input logic [15:0] w);
    wr(`REG_EXT_POINTER, x);
    wr(`REG_EXT_WINDOW, w);
  endtask
  task automatic ext_rd(input logic [15:0] x, output logic [15:0] q);
    wr(`REG_EXT_POINTER, x);
    rd(`REG_EXT_WINDOW, q);
  endtask
endmodule // mgmt_ctrl_model

// ===== tb/phy_interrupt_and_config_regs_tb.sv
// Self-checking bench for the management register block
// Assumes the model and checker files are compiled ahead of it
`include "phy_mgmt_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module phy_interrupt_and_config_regs_tb;
  import phy_mgmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst = 1'b1, mgmt_rd, mgmt_wr;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, d, v, p, max_rx_frame_bytes;
  logic [15:0] event_pulse = 16'h0000;
  logic        soft_reset = 1'b0, wake_irq_level = 1'b0, autoneg_attempt_fail = 1'b0;
  logic        rx_error = 1'b0, speed_10m = 1'b0, tx_data_pending = 1'b0, strap_irq_pin = 1'b1;
  logic        link_pulse_pending = 1'b0, rx_dv_in = 1'b0, crs_dv_in = 1'b0, link_up = 1'b0;
  logic        general_irq, shared_irq_pin, downgrade_active, tx_dac_on, rmii_crs_dv;
  logic        reduced_interface_variant_one, reduced_interface_variant_two;
  logic        reverse_media_interface, mac_clock_input, remote_loopback, wake_enable;
  logic [31:0] seed = 32'hCCC2D780;
  int          n_errors = 0, n_tests = 0, lim, k;
  int          src[9] = '{15, 14, 13, 12, 11, 10, 6, 1, 0};
  logic [15:0] cfgs[4] = '{16'h082C, 16'h0820, 16'h080C, 16'h0822};

  phy_interrupt_and_config_regs #(.STABLE_CYCLES(20)) DUT (
    .sys_clk, .rst, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .soft_reset,
    .event_pulse, .wake_irq_level, .strap_irq_pin, .strap_clk_input(1'b1),
    .link_up, .autoneg_attempt_fail, .rx_error, .speed_10m, .tx_data_pending,
    .link_pulse_pending, .rx_dv_in, .crs_dv_in, .general_irq, .shared_irq_pin,
    .downgrade_active, .tx_dac_on, .max_rx_frame_bytes, .rmii_crs_dv,
    .reduced_interface_variant_one, .reduced_interface_variant_two,
    .reverse_media_interface, .mac_clock_input, .remote_loopback, .wake_enable);
  mgmt_ctrl_model u_mgmt (.sys_clk, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_rdata);

  // Helpers: random source, expectations, pulses, verdict
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic int dg_limit(input logic [15:0] c);
    return c[5] ? int'(c[4:2]) + 2 : 0;
  endfunction
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
  endtask
  task automatic end_sim();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #5000000 n_errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    // Reset values, unmapped read, pointer readback
    u_mgmt.rd(`REG_INT_ENABLE, d); `CHK(d, `RST_INT_ENABLE)
    u_mgmt.rd(`REG_SPEED_CFG, d); `CHK(d, `RST_SPEED_CFG)
    u_mgmt.rd(5'h03, d); `CHK(d, 16'h0000)
    u_mgmt.ext_rd(`EXT_TEN_MEG_POWER, d); `CHK(d, `RST_TEN_MEG_POWER)
    u_mgmt.ext_rd(`EXT_COMBO, d); `CHK(d, 16'h0001)
    u_mgmt.ext_rd(`EXT_PAD, d); `CHK(d, `RST_PAD)
    u_mgmt.rd(`REG_EXT_POINTER, d); `CHK(d, `EXT_PAD)
    // Each source masked while the others are enabled, then enabled alone
    foreach (src[i]) begin
      u_mgmt.wr(`REG_INT_ENABLE, `INT_IMPL_MASK & ~(16'h0001 << src[i]));
      @(negedge sys_clk) event_pulse = 16'h0001 << src[i];
      @(negedge sys_clk) event_pulse = 16'h0000;
      `CHK(general_irq, 1'b0)
      u_mgmt.rd(`REG_INT_STATUS, d); `CHK(d, 16'h0001 << src[i])
      u_mgmt.wr(`REG_INT_ENABLE, 16'h0001 << src[i]);
      @(negedge sys_clk) event_pulse = 16'h0001 << src[i];
      @(negedge sys_clk) event_pulse = 16'h0000;
      `CHK(general_irq, 1'b1)
      u_mgmt.rd(`REG_INT_STATUS, d); `CHK(general_irq, 1'b0)
    end
    // Attempt limit and enable taken at software reset
    u_mgmt.wr(`REG_INT_ENABLE, 16'h0020);
    foreach (cfgs[i]) begin
      u_mgmt.wr(`REG_SPEED_CFG, cfgs[i]);
      pulse(soft_reset);
      // A bypassed timer turns each short link into a success
      lim = cfgs[i][1] ? 0 : dg_limit(cfgs[i]);
      for (k = 1; k <= 6; k++) begin
        if (k[0]) pulse(link_up);
        else pulse(autoneg_attempt_fail);
        repeat (3) @(negedge sys_clk);
        `CHK(downgrade_active, lim != 0 && k >= lim)
      end
      `CHK(general_irq, lim != 0)
      u_mgmt.rd(`REG_INT_STATUS, d); `CHK(d, lim != 0 ? 16'h0020 : 16'h0000)
    end
    // Latched read data holds; live read data follows the counter
    u_mgmt.rd(`REG_RX_ERR_COUNT, d); `CHK(d, 16'h0000)
    pulse(rx_error);
    repeat (2) @(negedge sys_clk);
    `CHK(mgmt_rdata, 16'h0000)
    u_mgmt.wr(`REG_SPEED_CFG, 16'h002C);
    u_mgmt.rd(`REG_RX_ERR_COUNT, d); `CHK(d, 16'h0001)
    pulse(rx_error);
    repeat (2) @(negedge sys_clk);
    `CHK(mgmt_rdata, 16'h0002)
    u_mgmt.wr(`REG_SPEED_CFG, 16'h082C);
    // Counter saturates instead of wrapping
    @(negedge sys_clk) rx_error = 1'b1;
    repeat (65540) @(negedge sys_clk);
    rx_error = 1'b0;
    u_mgmt.rd(`REG_RX_ERR_COUNT, d); `CHK(d, `RX_ERR_SAT)
    // Random combo and power settings, every interface mode twice
    for (k = 0; k < 8; k++) begin
      v = rnd();
      v[1:0] = k[1:0];
      p = rnd();
      u_mgmt.ext_wr(`EXT_COMBO, v);
      u_mgmt.ext_wr(`EXT_TEN_MEG_POWER, p);
      d = rnd();
      {speed_10m, tx_data_pending, link_pulse_pending} = {d[0], d[1] & d[2], d[3] & d[4]};
      {rx_dv_in, crs_dv_in} = d[6:5];
      @(negedge sys_clk);
      `CHK(tx_dac_on, !(p[10] && d[0] && !(d[1] & d[2]) && !(d[3] & d[4])))
      `CHK(max_rx_frame_bytes, v[5] ? `FRAME_MAX_JUMBO : `FRAME_MAX_NORMAL)
      `CHK(rmii_crs_dv, v[4] ? d[6] : d[5])
      `CHK({reduced_interface_variant_one, reduced_interface_variant_two,
            reverse_media_interface, mac_clock_input},
           {v[1:0] == 2'b11, v[1:0] == 2'b10, v[1:0] == 2'b01, v[0]})
      `CHK({remote_loopback, wake_enable}, {v[11], v[2]})
      u_mgmt.ext_rd(`EXT_COMBO, d); `CHK(d, v)
    end
    // Pad select hands the shared pin to the wake level
    u_mgmt.wr(`REG_INT_ENABLE, 16'h0040);
    u_mgmt.ext_wr(`EXT_PAD, `RST_PAD & 16'h7FFF);
    @(negedge sys_clk) wake_irq_level = 1'b1;
    @(negedge sys_clk);
    `CHK({shared_irq_pin, general_irq}, 2'b10)
    u_mgmt.ext_wr(`EXT_PAD, `RST_PAD);
    `CHK(shared_irq_pin, 1'b0)
    // Reset again with the strap low: shared pin stays general
    strap_irq_pin = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    u_mgmt.wr(`REG_INT_ENABLE, 16'h0040);
    u_mgmt.ext_wr(`EXT_PAD, 16'h0000);
    `CHK({shared_irq_pin, general_irq}, 2'b00)
    end_sim();
  end
endmodule // phy_interrupt_and_config_regs_tb
